// [rtl/stop_err_pkg.sv]
// Package for the stop-command error status block: register map, field
// positions, reset values and timing counts.
// Assumes a plain address/strobe register port and a 20 MHz system clock.
package stop_err_pkg;

    // Register offsets on the plain register port
    localparam logic [31:0] SIG_ENABLE_OFFSET   = 32'h4a80003a; // Error signal enable
    localparam logic [31:0] DETAIL_OFFSET       = 32'h4a80003c; // Error detail register
    localparam logic [31:0] EVENT_STATUS_OFFSET = 32'h4a800100; // Sticky event status
    localparam logic [31:0] EVENT_MASK_OFFSET   = 32'h4a800104; // Event mask

    // Field positions in the detail register
    localparam int NOT_EXEC_POS = 0; // Stop command not executed
    localparam int TIMEOUT_POS  = 1; // Response timeout
    localparam int CRC_POS      = 2; // Response CRC error
    localparam int ENDBIT_POS   = 3; // Response end bit error
    localparam int INDEX_POS    = 4; // Response index error
    localparam int HELD_POS     = 7; // Dataless command held back

    // Field position in the signal enable register
    localparam int SIG_STOP_POS = 8; // Stop error signal enable

    // Field position in event status and mask
    localparam int EVT_STOP_POS = 0; // Stop error event

    // Reset values
    localparam logic [15:0] DETAIL_RESET = 16'h0000; // Detail register
    localparam logic [15:0] SIGEN_RESET  = 16'h0000; // Signal enable
    localparam logic [15:0] EVENT_RESET  = 16'h0000; // Status and mask
    localparam logic [15:0] READ_ZERO    = 16'h0000; // Unmapped read value

    // Writable bits of the registers held here
    localparam logic [15:0] SIGEN_WMASK  = 16'h0100; // Only stop error enable
    localparam logic [15:0] EVENT_WMASK  = 16'h0001; // Only stop error event

    // Response timeout in card clock cycles
    localparam int          TIMEOUT_CYCLES = 64;
    localparam logic [6:0]  TIMEOUT_LAST   = 7'(TIMEOUT_CYCLES - 1);

    // Response frame layout, bit numbers counted from the start bit
    localparam logic [5:0]  IDX_FIRST_BIT = 6'h02; // First index bit
    localparam logic [5:0]  IDX_LAST_BIT  = 6'h07; // Last index bit
    localparam logic [5:0]  CRC_FIRST_BIT = 6'h28; // First CRC bit
    localparam logic [5:0]  END_BIT       = 6'h2f; // End bit
    localparam logic [5:0]  STOP_CMD_INDEX = 6'h0c; // Expected response index

    // CRC7 polynomial taps
    localparam logic [6:0]  CRC7_POLY = 7'h09;

    // Combined decode of CRC and timeout bits
    typedef enum logic [1:0]
    {
        KIND_NONE     = 2'h0,
        KIND_TIMEOUT  = 2'h1,
        KIND_CRC      = 2'h2,
        KIND_CONFLICT = 2'h3
    } err_kind_t;

endpackage : stop_err_pkg

// [rtl/stop_err_status.sv]
// Stop-command error status capture with response checker and interrupt.
// Assumes register port and control pulses on CLK; card clock and command
// line arrive as pins from another domain and are synchronised here.
//
// Summary of operation
// R1 - Detail valid only while summary flag set
// R2 - Bit 7: held command due to errors
// R3 - Bit 4: response index mismatch
// R4 - Bit 3: response end bit zero
// R5 - Bit 2: response CRC check failed
// R6 - Bit 1: no response within 64 clocks
// R7 - Timeout makes bits 4..2 meaningless
// R8 - Bit 0: stop command could not be sent
// R9 - Bit 0 makes bits 4..1 meaningless
// R10 - CRC and timeout decode together, both conflict
// R11 - Bit 0 set if blocked, cleared if sent
// R12 - Bits 4..1 evaluated at response end bit
// R13 - Bit 7 updated just before detail read
// R14 - Interrupt on bits 0..4 rising, not 7
// R15 - Read-only, reset zero, reserved bits zero
// R16 - Host line needs signal enable bit 8
// R17 - Timeout counter restarts, stops on start
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

module stop_err_status
    import stop_err_pkg::*;
(
    input  wire logic        CLK,           // System clock, 20 MHz
    input  wire logic        RST_N,         // Asynchronous reset, active low
    input  wire logic        CE,            // Clock enable, freezes state when low
    input  wire logic [31:0] ADDR,          // Register address
    input  wire logic [15:0] WDATA,         // Register write data
    input  wire logic        WR,            // Write strobe
    input  wire logic        RD,            // Read strobe
    output logic      [15:0] RDATA,         // Read data, cycle after RD
    input  wire logic        CARD_CLK,      // Card clock pin
    input  wire logic        CMD_IN,        // Command line pin
    input  wire logic        STOP_BLOCKED,  // Pulse: stop command cannot be sent
    input  wire logic        STOP_SENT,     // Pulse: end bit of stop command sent
    input  wire logic        CMD_WAITING,   // Level: dataless command pending
    output logic             STOP_ERR_FLAG, // Summary stop error flag
    output logic      [1:0]  ERR_KIND,      // Decoded CRC/timeout pair
    output logic             IRQ            // Level interrupt
);

    // Receiver states
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,   // No stop response expected
        ST_WAIT = 3'h2,   // Counting for the start bit
        ST_RECV = 3'h4    // Shifting the response in
    } rx_state_t;

    // One CRC7 step over a single bit
    function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic din);
        logic fb;
        fb = din ^ crc[6];
        crc7_step = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    endfunction : crc7_step

    // Decode of the CRC and timeout bits into an error kind
    function automatic err_kind_t decode_kind(input logic crc_bit, input logic tmo_bit);
        decode_kind = err_kind_t'({crc_bit, tmo_bit});
    endfunction : decode_kind

    // Synchronisers for pins
    logic        cclk_meta_reg;     // First stage, card clock
    logic        cclk_sync_reg;     // Second stage, card clock
    logic        cclk_prev_reg;     // Delayed copy for edge detect
    logic        cmd_meta_reg;      // First stage, command line
    logic        cmd_sync_reg;      // Second stage, command line

    // Receiver
    rx_state_t   state_reg;         // Receiver state
    rx_state_t   state_next;        // Next receiver state
    logic [6:0]  tmo_cnt_reg;       // Card clock edges since stop end bit
    logic [5:0]  bit_cnt_reg;       // Bit number in response frame
    logic [5:0]  index_reg;         // Received index
    logic [6:0]  crc_calc_reg;      // Computed CRC
    logic [6:0]  crc_rx_reg;        // Received CRC

    // Registers
    logic [15:0] detail_reg;        // Error detail register
    logic [15:0] detail_next;       // Next value of detail register
    logic [15:0] sig_en_reg;        // Error signal enable
    logic [15:0] evt_status_reg;    // Sticky event status
    logic [15:0] evt_mask_reg;      // Event mask
    logic [15:0] rdata_reg;         // Read data

    // Decoded strobes and events
    logic        cclk_rise;         // Card clock rising edge
    logic        timeout_hit;       // Response timeout reached
    logic        frame_end;         // End bit of response sampled
    logic        err_event;         // A detail error bit rose
    logic        rd_detail;         // Read of the detail register
    logic        rd_status;         // Read of the event status

    // Pin synchronisers, card clock
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cclk_meta_reg <= 1'b0;
            cclk_sync_reg <= 1'b0;
            cclk_prev_reg <= 1'b0;
        end
        else if (CE)
        begin
            cclk_meta_reg <= CARD_CLK;
            cclk_sync_reg <= cclk_meta_reg;
            cclk_prev_reg <= cclk_sync_reg;
        end
    end

    // Pin synchronisers, command line; idle level is high
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cmd_meta_reg <= 1'b1;
            cmd_sync_reg <= 1'b1;
        end
        else if (CE)
        begin
            cmd_meta_reg <= CMD_IN;
            cmd_sync_reg <= cmd_meta_reg;
        end
    end

    // Card clock edge, from synchronised stages only
    assign cclk_rise = cclk_sync_reg & ~cclk_prev_reg;

    // Timeout on the 64th card clock edge without a start bit
    assign timeout_hit = (state_reg == ST_WAIT) && cclk_rise && cmd_sync_reg
                         && (tmo_cnt_reg == TIMEOUT_LAST); // R6

    // End bit of the response frame
    assign frame_end = (state_reg == ST_RECV) && cclk_rise && (bit_cnt_reg == END_BIT);

    // Receiver next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                // Wait for the stop command end bit
                if (STOP_SENT)
                    state_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                // Start bit or timeout ends the wait
                if (STOP_SENT)
                    state_next = ST_WAIT;
                else if (cclk_rise && !cmd_sync_reg)
                    state_next = ST_RECV; // R17
                else if (timeout_hit)
                    state_next = ST_IDLE;
            end
            ST_RECV:
            begin
                // Frame ends at its end bit
                if (STOP_SENT)
                    state_next = ST_WAIT;
                else if (frame_end)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Receiver state register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= ST_IDLE;
        else if (CE)
            state_reg <= state_next;
    end

    // Timeout counter, restarted by each stop command
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            tmo_cnt_reg <= 7'h00;
        else if (CE)
        begin
            if (STOP_SENT)
                tmo_cnt_reg <= 7'h00; // R17
            else if (state_reg == ST_WAIT && cclk_rise)
                tmo_cnt_reg <= tmo_cnt_reg + 7'h01;
        end
    end

    // Frame bit counter and capture of index and CRC
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_cnt_reg  <= 6'h00;
            index_reg    <= 6'h00;
            crc_calc_reg <= 7'h00;
            crc_rx_reg   <= 7'h00;
        end
        else if (CE && cclk_rise)
        begin
            if (state_reg == ST_WAIT)
            begin
                // Start bit is bit 0; CRC of a zero bit from zero stays zero
                bit_cnt_reg  <= 6'h01;
                crc_calc_reg <= 7'h00;
            end
            else if (state_reg == ST_RECV)
            begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                // Index bits, most significant first
                if (bit_cnt_reg >= IDX_FIRST_BIT && bit_cnt_reg <= IDX_LAST_BIT)
                    index_reg <= {index_reg[4:0], cmd_sync_reg};
                // CRC over the 40 bits before the CRC field
                if (bit_cnt_reg < CRC_FIRST_BIT)
                    crc_calc_reg <= crc7_step(crc_calc_reg, cmd_sync_reg); // R5
                else if (bit_cnt_reg < END_BIT)
                    crc_rx_reg <= {crc_rx_reg[5:0], cmd_sync_reg};
            end
        end
    end

    // Next value of the detail register
    always_comb
    begin
        detail_next = detail_reg;
        if (STOP_BLOCKED)
            detail_next[NOT_EXEC_POS] = 1'b1; // R11 R8
        else if (STOP_SENT)
            detail_next[NOT_EXEC_POS] = 1'b0; // R11
        if (timeout_hit)
        begin
            // Other response bits carry no meaning after a timeout
            detail_next[TIMEOUT_POS] = 1'b1; // R6 R7
            detail_next[CRC_POS]     = 1'b0;
            detail_next[ENDBIT_POS]  = 1'b0;
            detail_next[INDEX_POS]   = 1'b0;
        end
        else if (frame_end)
        begin
            // Full evaluation at the response end bit
            detail_next[TIMEOUT_POS] = 1'b0; // R12
            detail_next[CRC_POS]     = (crc_calc_reg != crc_rx_reg); // R5 R12
            detail_next[ENDBIT_POS]  = ~cmd_sync_reg; // R4 R12
            detail_next[INDEX_POS]   = (index_reg != STOP_CMD_INDEX); // R3 R12
        end
        if (rd_detail)
            detail_next[HELD_POS] = CMD_WAITING
                                    & (|detail_next[INDEX_POS:TIMEOUT_POS]); // R2 R13
        detail_next[15:8] = 8'h00; // R15
        detail_next[6:5]  = 2'h0; // R15
    end

    // A newly set error bit among 0..4 raises the event; bit 7 does not
    assign err_event = |(detail_next[INDEX_POS:NOT_EXEC_POS]
                         & ~detail_reg[INDEX_POS:NOT_EXEC_POS]); // R14

    // Register decode
    assign rd_detail = RD && (ADDR == DETAIL_OFFSET);
    assign rd_status = RD && (ADDR == EVENT_STATUS_OFFSET);

    // Detail register, read-only to software
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            detail_reg <= DETAIL_RESET; // R15
        else if (CE)
            detail_reg <= detail_next;
    end

    // Signal enable register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            sig_en_reg <= SIGEN_RESET;
        else if (CE && WR && ADDR == SIG_ENABLE_OFFSET)
            sig_en_reg <= WDATA & SIGEN_WMASK;
    end

    // Event mask register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            evt_mask_reg <= EVENT_RESET;
        else if (CE && WR && ADDR == EVENT_MASK_OFFSET)
            evt_mask_reg <= WDATA & EVENT_WMASK;
    end

    // Sticky event status; read clears, new event wins
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            evt_status_reg <= EVENT_RESET;
        else if (CE)
        begin
            if (err_event)
                evt_status_reg[EVT_STOP_POS] <= 1'b1; // R14
            else if (rd_status)
                evt_status_reg[EVT_STOP_POS] <= 1'b0;
        end
    end

    // Read data, valid only in the cycle after RD
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_reg <= READ_ZERO;
        else if (CE)
        begin
            if (!RD)
                rdata_reg <= READ_ZERO;
            else
            begin
                case (ADDR)
                    DETAIL_OFFSET:       rdata_reg <= detail_next; // R13 R15
                    SIG_ENABLE_OFFSET:   rdata_reg <= sig_en_reg;
                    EVENT_STATUS_OFFSET: rdata_reg <= evt_status_reg;
                    EVENT_MASK_OFFSET:   rdata_reg <= evt_mask_reg;
                    default:             rdata_reg <= READ_ZERO;
                endcase
            end
        end
    end

    // Outputs
    assign RDATA = rdata_reg;

    // Summary flag gates the meaning of the detail register
    assign STOP_ERR_FLAG = evt_status_reg[EVT_STOP_POS]; // R1

    // Combined CRC/timeout decode; not-executed overrides the response bits
    assign ERR_KIND = detail_reg[NOT_EXEC_POS] ? KIND_NONE
                      : decode_kind(detail_reg[CRC_POS], detail_reg[TIMEOUT_POS]); // R10 R9

    // Interrupt reaches the host line only with mask and signal enable
    assign IRQ = (evt_status_reg[EVT_STOP_POS] & evt_mask_reg[EVT_STOP_POS])
                 & sig_en_reg[SIG_STOP_POS]; // R16

endmodule : stop_err_status

// [sim/stop_err_status_checker.sv]
// Checker for the stop error status block, watching top ports only.
// Assumes all strobes and pulses are on CLK; card clock is raw.
`timescale 1ns/10ps
module stop_err_checker
    import stop_err_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic [31:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        CARD_CLK,
    input wire logic        STOP_BLOCKED,
    input wire logic        STOP_SENT,
    input wire logic        CMD_WAITING,
    input wire logic        STOP_ERR_FLAG,
    input wire logic [1:0]  ERR_KIND,
    input wire logic        IRQ
);
    logic       sigen_reg; // Mirror of signal enable
    logic       mask_reg;  // Mirror of event mask
    logic       card_reg;  // Last card clock level
    logic [3:0] age_reg;   // Cycles since card clock rise

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Mirror enable and mask writes
    always_ff @(posedge CLK or negedge RST_N)
        if (!RST_N)
        begin
            sigen_reg <= 1'b0;
            mask_reg  <= 1'b0;
        end
        else if (CE && WR && ADDR == SIG_ENABLE_OFFSET)
            sigen_reg <= WDATA[SIG_STOP_POS];
        else if (CE && WR && ADDR == EVENT_MASK_OFFSET)
            mask_reg <= WDATA[EVT_STOP_POS];

    // Saturating age of the last card clock rise
    always_ff @(posedge CLK or negedge RST_N)
        if (!RST_N)
        begin
            card_reg <= 1'b0;
            age_reg  <= 4'hf;
        end
        else
        begin
            card_reg <= CARD_CLK;
            age_reg  <= (CARD_CLK && !card_reg) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
        end

    sequence detail_read;
        CE && RD && ADDR == DETAIL_OFFSET;
    endsequence
    sequence status_read;
        CE && RD && ADDR == EVENT_STATUS_OFFSET;
    endsequence

    a_rdata_idle_zero: assert property (CE && !RD |=> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    a_reserved_read_zero: assert property (detail_read |=> RDATA[15:8] == 8'h00 && RDATA[6:5] == 2'h0)
        else $error("reserved detail bits not zero");
    a_held_bit_value: assert property (detail_read |=> RDATA[7] == ($past(CMD_WAITING) && |RDATA[4:1]))
        else $error("held command bit wrong");
    a_kind_decode_match: assert property (detail_read |=> ERR_KIND == (RDATA[0] ? 2'h0 : RDATA[2:1]))
        else $error("error kind disagrees with detail");
    a_irq_enable_gate: assert property (IRQ == (STOP_ERR_FLAG && mask_reg && sigen_reg))
        else $error("interrupt level wrong");
    a_blocked_not_exec: assert property (CE && STOP_BLOCKED ##1 !STOP_SENT ##1 detail_read |=> RDATA[0])
        else $error("not executed bit missing");
    a_flag_stays_sticky: assert property (STOP_ERR_FLAG && CE && !RD |=> STOP_ERR_FLAG)
        else $error("error flag dropped without read");
    a_status_read_clear: assert property (status_read ##0 (!STOP_BLOCKED && age_reg > 4'h5) |=> !STOP_ERR_FLAG && RDATA[15:1] == 15'h0)
        else $error("status read did not clear");
    a_kind_card_paced: assert property ($changed(ERR_KIND) && !$past(STOP_BLOCKED) && !$past(STOP_SENT) |-> age_reg <= 4'h5)
        else $error("error kind changed without card clock");
endmodule : stop_err_checker

// [sim/sd_card_model.sv]
// Card side of the command line: silent or one reply frame per episode.
// Assumes start rises after the stop command end bit was signalled.
`timescale 1ns/10ps
module sd_card_model
(
    input  wire logic       start,    // Begin one episode
    input  wire logic       respond,  // Reply, else stay silent
    input  wire logic [5:0] index,    // Index to return
    input  wire logic       crc_bad,  // Corrupt the CRC
    input  wire logic       end_bad,  // Zero end bit
    output logic            card_clk, // Card clock, still between episodes
    output logic            cmd_line, // Command line, pulled up when released
    output logic            done      // Episode finished
);
    logic [47:0] frame; // Reply, start bit first
    logic [6:0]  crc;   // Running CRC7
    int          n;     // Bit counter

    // One episode per start rise
    initial
    begin
        card_clk = 1'b0;
        cmd_line = 1'b1;
        done     = 1'b0;
        forever
        begin
            @(posedge start);
            done  = 1'b0;
            #37;
            frame = {2'b00, index, 32'h0000_0a5c, 8'h01};
            crc   = 7'h00;
            for (n = 47; n >= 8; n--)
                crc = {crc[5:0], 1'b0} ^ ((frame[n] ^ crc[6]) ? 7'h09 : 7'h00);
            frame[7:1] = crc ^ {6'h0, crc_bad};
            frame[0]   = !end_bad;
            // Silence runs past the reply window
            for (n = 0; n < (respond ? 52 : 70); n++)
            begin
                #200 card_clk = 1'b1;
                #200 card_clk = 1'b0;
                cmd_line = (respond && n >= 2 && n < 50) ? frame[49 - n] : 1'b1;
            end
            done = 1'b1;
        end
    end
endmodule : sd_card_model

// [sim/auto_stop_cmd_error_status_test.sv]
// Bench for the stop error status block, driving its register port.
// Assumes the card model and checker files are compiled before it.
`timescale 1ns/10ps
module auto_stop_cmd_error_status_test
    import stop_err_pkg::*;
;
    logic        clk, rst_n, ce, wr_s, rd_s, blocked, sent, waiting;
    logic [31:0] addr;
    logic [15:0] wdata, rdata;
    logic        card_clk, cmd_line, flag, irq, start, respond, crc_bad, end_bad, done;
    logic [1:0]  err_kind;
    logic [5:0]  index;
    int          bad_count, checks_done, j;
    logic [15:0] e;
    // Table: reply, index, bad CRC, bad end bit
    logic [8:0]  stim [6] = '{9'h114, 9'h030, 9'h130, 9'h132, 9'h131, 9'h130};
    logic [15:0] exp_tab [6] = '{16'h0010, 16'h0002, 16'h0000, 16'h0004, 16'h0008, 16'h0000};

    stop_err_status dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .CARD_CLK(card_clk), .CMD_IN(cmd_line),
        .STOP_BLOCKED(blocked), .STOP_SENT(sent), .CMD_WAITING(waiting),
        .STOP_ERR_FLAG(flag), .ERR_KIND(err_kind), .IRQ(irq));
    sd_card_model card (.start(start), .respond(respond), .index(index), .crc_bad(crc_bad),
        .end_bad(end_bad), .card_clk(card_clk), .cmd_line(cmd_line), .done(done));

    // System clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        #1;
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        // Let the write settle before any caller samples an output
        #1;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        // Read data is launched by this edge; take it once it stands
        #1;
        check(rdata, exp);
    endtask : rd

    // One-cycle stop pulse: blocked or sent
    task automatic pulse(input logic blk);
        @(posedge clk);
        blocked <= blk;
        sent    <= !blk;
        @(posedge clk);
        blocked <= 1'b0;
        sent    <= 1'b0;
    endtask : pulse

    // Sent stop then one card episode, bounded wait
    task automatic episode(input logic [8:0] s);
        int k;
        pulse(1'b0);
        respond <= s[8];
        index   <= s[7:2];
        crc_bad <= s[1];
        end_bad <= s[0];
        start   <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 2000 && done !== 1'b1; k++)
            @(posedge clk);
        start <= 1'b0;
        repeat (8) @(posedge clk);
        if (done !== 1'b1)
        begin
            bad_count++;
            wrap_up();
        end
    endtask : episode

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial
    begin
        {rst_n, wr_s, rd_s, blocked, sent, waiting, start} = 7'h00;
        {respond, crc_bad, end_bad, index, addr, wdata} = '0;
        ce = 1'b1;
        bad_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(DETAIL_OFFSET, 16'h0000);
        wr(DETAIL_OFFSET, 16'hffff);
        rd(DETAIL_OFFSET, 16'h0000);
        rd(32'h4a800200, 16'h0000);
        wr(SIG_ENABLE_OFFSET, 16'hffff);
        rd(SIG_ENABLE_OFFSET, 16'h0100);
        wr(EVENT_MASK_OFFSET, 16'hffff);
        rd(EVENT_MASK_OFFSET, 16'h0001);
        for (j = 0; j < 6; j++)
        begin
            waiting <= j[0];
            episode(stim[j]);
            e = exp_tab[j];
            check(irq, e != 0);
            check(err_kind, {e[2], e[1]});
            rd(DETAIL_OFFSET, e | ((j[0] && |e[4:1]) ? 16'h0080 : 16'h0000));
            rd(EVENT_STATUS_OFFSET, e != 0);
            check(irq, 1'b0);
        end
        pulse(1'b1);
        rd(DETAIL_OFFSET, 16'h0001);
        check(err_kind, 2'h0);
        check(irq, 1'b1);
        wr(SIG_ENABLE_OFFSET, 16'h0000);
        check(irq, 1'b0);
        check(flag, 1'b1);
        rd(EVENT_STATUS_OFFSET, 16'h0001);
        episode(9'h130);
        rd(DETAIL_OFFSET, 16'h0000);
        check(flag, 1'b0);
        wrap_up();
    end
endmodule : auto_stop_cmd_error_status_test

bind stop_err_status stop_err_checker chk (.CLK, .RST_N, .CE, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .CARD_CLK, .STOP_BLOCKED, .STOP_SENT, .CMD_WAITING, .STOP_ERR_FLAG,
    .ERR_KIND, .IRQ);
